// >>> src/dsa_consts.svh
// Constants for the data-space access unit
`ifndef DSA_CONSTS_SVH
`define DSA_CONSTS_SVH
`define DSA_WIN_BIT 15
`define DSA_SFR_TOP 16'h07ff
`define DSA_NEAR_TOP 16'h1fff
`define DSA_NEAR_W 13
`define DSA_STEP_BYTE 16'h0001
`define DSA_STEP_WORD 16'h0002
`define DSA_VT_END 24'h000100
`define DSA_PAGE_SHIFT 11
`define DSA_OTP_BASE 24'h801700
`define DSA_OTP_TOP 24'h8017fe
`define DSA_CFG_WORDS 4'h9
`endif

// >>> src/dsa_pkg.sv
// Types for the data-space access unit
package dsa_pkg;
   typedef enum logic [1:0] {
      DSA_IDLE = 2'b00,
      DSA_LOAD = 2'b01,
      DSA_DONE = 2'b11
   } dsa_cfg_state_t;
   typedef enum logic [1:0] {
      DSA_EXT_NONE = 2'b00,
      DSA_EXT_SIGN = 2'b01,
      DSA_EXT_ZERO = 2'b10
   } dsa_ext_t;
endpackage

// >>> src/dsa_unit.sv
// Data-space access unit: address decode, byte lanes, alignment, segments
// How it works
// (R01) Separate read and write address generators for data space.
// (R02) 16-bit byte addresses; lower half maps to on-chip memory.
// (R03) Upper half routes to the extended window space.
// (R04) Low byte at even address, high byte at odd address.
// (R05) Post-increment steps pointer by one for bytes, two for words.
// (R06) Byte read fetches the word; bit zero selects the byte onto low lane.
// (R07) Byte write strobes only the addressed lane.
// (R08) Word access to odd address raises address error trap.
// (R09) Misaligned read completes; misaligned write suppressed; trap follows.
// (R10) Byte load into working register keeps its high byte.
// (R11) Sign-extend and zero-extend operations on working register values.
// (R12) Direct instructions reach first 8 Kbytes via 13-bit field.
// (R13) Move instructions reach all data space via 16-bit field.
// (R14) Lowest 2 Kbytes are special-function registers.
// (R15) Unimplemented special-function addresses read zero.
// (R16) Segment limit field sizes privileged and unprivileged code segments.
// (R17) Configuration words load from configuration segment during reset.
// (R18) One-time area writable always, never erased, survives chip erase.
// (R19) Software programs each one-time location once only.
// (R20) Alternate vector table at (limit minus one) times 0x800 when enabled.
// (R21) Misalignment checked on bit zero, flagged in the access cycle.
// (R22) Read and write addresses computed independently each cycle.
`timescale 1ns/10ps
`include "dsa_consts.svh"
module dsa_unit
   import dsa_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,

   // Read address generator
   input wire logic RD_REQ,
   input wire logic RD_BYTE,
   input wire logic RD_DIRECT,
   input wire logic RD_MOV,
   input wire logic RD_POSTINC,
   input wire logic [15:0] RD_PTR,
   input wire logic [15:0] RD_LIT,
   output logic [15:0] RD_PTR_NEXT,

   // Write address generator
   input wire logic WR_REQ,
   input wire logic WR_BYTE,
   input wire logic WR_DIRECT,
   input wire logic WR_MOV,
   input wire logic WR_POSTINC,
   input wire logic [15:0] WR_PTR,
   input wire logic [15:0] WR_LIT,
   input wire logic [15:0] WR_DATA,
   output logic [15:0] WR_PTR_NEXT,

   // Memory side
   output logic [14:0] MEM_RD_ADDR,
   output logic MEM_RD_EN,
   input wire logic [15:0] MEM_RD_DATA,
   output logic [14:0] MEM_WR_ADDR,
   output logic [1:0] MEM_WR_LANE,
   output logic [15:0] MEM_WR_DATA,
   input wire logic SFR_RD_HIT,

   // Extended window side
   output logic EXT_RD_EN,
   output logic EXT_WR_EN,
   input wire logic [15:0] EXT_RD_DATA,

   // Read result and working register merge
   output logic [15:0] RD_DATA,
   input wire logic [15:0] WREG_OLD,
   input wire logic [1:0] EXT_OP,
   output logic [15:0] WREG_NEW,

   // Address error
   output logic ADDR_ERR,
   output logic ADDR_TRAP,

   // Configuration load and segments
   input wire logic [15:0] CFG_DATA,
   output logic [3:0] CFG_INDEX,
   output logic CFG_BUSY,
   output logic [12:0] SEGMENT_LIMIT_FIELD,
   output logic [23:0] PRIVILEGED_CODE_SEGMENT,
   output logic [23:0] UNPRIVILEGED_CODE_SEGMENT,
   output logic [23:0] ALTERNATE_VECTOR_TABLE,
   output logic ALT_TABLE_ON,

   // One-time area access check
   input wire logic [23:0] NVM_ADDR,
   input wire logic NVM_ERASE,
   output logic NVM_ERASE_OK
);
   // ==========================================
   // Effective address generation
   logic [15:0] rd_ea;
   logic [15:0] wr_ea;
   logic rd_mis;
   logic wr_mis;
   logic rd_in_sfr;
   logic rd_ext;
   logic wr_ext;
   logic rd_ok;
   logic wr_ok;
   logic rd_lane_q;
   logic rd_byte_q;
   logic rd_ext_q;
   logic rd_zero_q;
   logic [15:0] rd_word;
   logic [7:0] rd_sel;

   // Near direct drops the top three bits, so a literal above 1fff wraps
   // into the low 8 Kbytes; far targets need the move form or a pointer
   // Each generator picks its own source, near direct keeps 13 bits
   always_comb begin
      if (RD_DIRECT && !RD_MOV) begin
         rd_ea = {3'h0, RD_LIT[`DSA_NEAR_W-1:0]}; // [R12] [R01] [R22]
      end else if (RD_DIRECT) begin
         rd_ea = RD_LIT; // [R13]
      end else begin
         rd_ea = RD_PTR;
      end
      if (WR_DIRECT && !WR_MOV) begin
         wr_ea = {3'h0, WR_LIT[`DSA_NEAR_W-1:0]}; // [R12] [R01] [R22]
      end else if (WR_DIRECT) begin
         wr_ea = WR_LIT; // [R13]
      end else begin
         wr_ea = WR_PTR;
      end
   end

   // Step size follows the operand size
   logic [15:0] rd_step;
   logic [15:0] wr_step;
   assign rd_step = RD_BYTE ? `DSA_STEP_BYTE : `DSA_STEP_WORD; // [R05]
   assign wr_step = WR_BYTE ? `DSA_STEP_BYTE : `DSA_STEP_WORD; // [R05]

   // Pointer post-increment scaled by size
   assign RD_PTR_NEXT = RD_POSTINC ? RD_PTR + rd_step : RD_PTR; // [R05]
   assign WR_PTR_NEXT = WR_POSTINC ? WR_PTR + wr_step : WR_PTR; // [R05]

   // Alignment check on bit zero, same cycle
   // Kept combinational so the core sees the error in the access cycle
   assign rd_mis = RD_REQ && !RD_BYTE && rd_ea[0]; // [R08] [R21]
   assign wr_mis = WR_REQ && !WR_BYTE && wr_ea[0]; // [R08] [R21]
   assign ADDR_ERR = rd_mis || wr_mis; // [R21]

   // Window decode: upper half goes to extended space
   // Bit 15 alone picks on-chip memory or the window, no finer decode
   // A misaligned read is still carried out, only writes are held off
   assign rd_ext = rd_ea[`DSA_WIN_BIT]; // [R03]
   assign wr_ext = wr_ea[`DSA_WIN_BIT]; // [R03]
   assign rd_in_sfr = (rd_ea <= `DSA_SFR_TOP); // [R14]
   assign rd_ok = RD_REQ; // [R09] misaligned read still completes
   assign wr_ok = WR_REQ && !wr_mis; // [R09]

   // Memory strobes
   // Word addresses drop bit zero; the top word address bit is always zero
   assign MEM_RD_ADDR = {1'b0, rd_ea[14:1]}; // [R02] word address, bit zero picks lane
   assign MEM_RD_EN = rd_ok && !rd_ext; // [R02]
   assign EXT_RD_EN = rd_ok && rd_ext; // [R03]
   assign MEM_WR_ADDR = {1'b0, wr_ea[14:1]}; // [R02]
   assign EXT_WR_EN = wr_ok && wr_ext; // [R03]

   // Lane strobes: even byte is low lane
   // Misaligned word writes and window writes leave both strobes low
   always_comb begin
      if (!wr_ok || wr_ext) begin
         MEM_WR_LANE = 2'h0;
      end else if (WR_BYTE) begin
         MEM_WR_LANE = wr_ea[0] ? 2'h2 : 2'h1; // [R07] [R04]
      end else begin
         MEM_WR_LANE = 2'h3;
      end
   end
   // The byte is copied onto both lanes; the strobe decides which lands
   assign MEM_WR_DATA = WR_BYTE ? {WR_DATA[7:0], WR_DATA[7:0]} : WR_DATA; // [R07]

   // ==========================================
   // Read return path, one cycle after the request
   // Lane, size and source are held for the answer cycle, since memory
   // returns its word one cycle after the strobe
   always_ff @(posedge CLK) begin
      if (SRST) begin
         rd_lane_q <= 1'b0;
         rd_byte_q <= 1'b0;
         rd_ext_q <= 1'b0;
         rd_zero_q <= 1'b0;
      end else begin
         rd_lane_q <= rd_ea[0];
         rd_byte_q <= RD_BYTE;
         rd_ext_q <= rd_ext;
         rd_zero_q <= rd_in_sfr && !SFR_RD_HIT; // [R15]
      end
   end

   // Unimplemented SFR reads give zero whatever the memory drives
   always_comb begin
      if (rd_zero_q) begin
         rd_word = 16'h0000; // [R15]
      end else if (rd_ext_q) begin
         rd_word = EXT_RD_DATA;
      end else begin
         rd_word = MEM_RD_DATA;
      end
      rd_sel = rd_lane_q ? rd_word[15:8] : rd_word[7:0]; // [R06] [R04]
      RD_DATA = rd_byte_q ? {8'h00, rd_sel} : rd_word; // [R06]
   end

   // Working register merge and extension ops
   // Extension ops act on the register's old value, not on the read data
   always_comb begin
      case (dsa_ext_t'(EXT_OP))
         DSA_EXT_SIGN: WREG_NEW = {{8{WREG_OLD[7]}}, WREG_OLD[7:0]}; // [R11]
         DSA_EXT_ZERO: WREG_NEW = {8'h00, WREG_OLD[7:0]}; // [R11]
         default: WREG_NEW = rd_byte_q ? {WREG_OLD[15:8], rd_sel} : rd_word; // [R10]
      endcase
   end

   // Trap is taken after the faulting instruction
   // Registered so the faulting access finishes before the trap is seen
   always_ff @(posedge CLK) begin
      if (SRST) begin
         ADDR_TRAP <= 1'b0;
      end else begin
         ADDR_TRAP <= ADDR_ERR; // [R09] [R08]
      end
   end

   // ==========================================
   // Configuration load during reset sequence
   // Runs once after every reset; CFG_BUSY holds the core off until all
   // nine configuration words, security and limit among them, have streamed in
   dsa_cfg_state_t state;
   dsa_cfg_state_t next_state;
   logic [3:0] cfg_idx;
   logic [15:0] sec_word;

   // Idle one cycle, then walk the word index up to the last word
   always_comb begin
      case (state)
         DSA_IDLE: next_state = DSA_LOAD;
         DSA_LOAD: next_state = (cfg_idx == `DSA_CFG_WORDS - 4'h1) ? DSA_DONE : DSA_LOAD;
         DSA_DONE: next_state = DSA_DONE;
         default: next_state = DSA_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         state <= DSA_IDLE;
         cfg_idx <= 4'h0;
      end else begin
         state <= next_state;
         if (state == DSA_LOAD) begin
            cfg_idx <= cfg_idx + 4'h1; // [R17]
         end
      end
   end

   // Capture security and limit words as they stream in
   // Index 0 is the security word, index 1 the limit word; the rest pass by
   always_ff @(posedge CLK) begin
      if (SRST) begin
         sec_word <= 16'h0000;
         SEGMENT_LIMIT_FIELD <= 13'h0000;
      end else if (state == DSA_LOAD) begin
         if (cfg_idx == 4'h0) begin
            sec_word <= CFG_DATA; // [R17]
         end
         if (cfg_idx == 4'h1) begin
            SEGMENT_LIMIT_FIELD <= CFG_DATA[12:0]; // [R16] [R17]
         end
      end
   end
   assign CFG_INDEX = cfg_idx;
   assign CFG_BUSY = (state != DSA_DONE);

   // ==========================================
   // Segment placement
   // Privileged segment always starts right after the vector table
   // Outputs lag their inputs by one cycle; the unprivileged start lags the
   // alternate-table flag by one more, settled well before the load ends
   logic [23:0] lim_addr;
   logic seg_present;
   assign lim_addr = {SEGMENT_LIMIT_FIELD - 13'h1, 11'h000}; // [R20] (limit-1) * 0x800
   assign seg_present = SEGMENT_LIMIT_FIELD > 13'h1;
   always_ff @(posedge CLK) begin
      if (SRST) begin
         ALT_TABLE_ON <= 1'b0;
         PRIVILEGED_CODE_SEGMENT <= 24'h000000;
         UNPRIVILEGED_CODE_SEGMENT <= 24'h000000;
         ALTERNATE_VECTOR_TABLE <= 24'h000000;
      end else begin
         // Alternate table needs enable bit clear and a limit field above two
         ALT_TABLE_ON <= !sec_word[15] && (SEGMENT_LIMIT_FIELD > 13'h2); // [R20]
         PRIVILEGED_CODE_SEGMENT <= `DSA_VT_END; // [R16]
         ALTERNATE_VECTOR_TABLE <= lim_addr; // [R20]
         UNPRIVILEGED_CODE_SEGMENT <= !seg_present ? `DSA_VT_END
            : (ALT_TABLE_ON ? lim_addr + (24'h1 << `DSA_PAGE_SHIFT) : lim_addr); // [R16]
      end
   end

   // One-time area is never erased
   // Only erase is refused over the area; writes pass in every mode
   assign NVM_ERASE_OK = NVM_ERASE && !(NVM_ADDR >= `DSA_OTP_BASE && NVM_ADDR <= `DSA_OTP_TOP); // [R18]
endmodule

// >>> dv/dsa_unit_monitor.sv
// Assertion checker for the data-space access unit
`timescale 1ns/10ps
module dsa_unit_chk (
   // Clock, reset and request controls
   input wire logic CLK, SRST, RD_REQ, RD_BYTE, RD_DIRECT, RD_MOV, RD_POSTINC,
   input wire logic WR_REQ, WR_BYTE, WR_DIRECT, NVM_ERASE,
   // Pointers and literals
   input wire logic [15:0] RD_PTR, RD_LIT, RD_PTR_NEXT, WR_PTR,
   // Decode results
   input wire logic [14:0] MEM_RD_ADDR, MEM_WR_ADDR,
   input wire logic [1:0] MEM_WR_LANE,
   input wire logic MEM_RD_EN, EXT_RD_EN, EXT_WR_EN, ADDR_ERR, ADDR_TRAP, CFG_BUSY, NVM_ERASE_OK,
   input wire logic [23:0] NVM_ADDR
);
   // ============================================================
   // Properties
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   a_rd_step: assert property (RD_POSTINC && !RD_DIRECT |-> RD_PTR_NEXT == RD_PTR + (RD_BYTE ? 16'h0001 : 16'h0002))
      else $error("pointer step wrong");
   a_rd_split: assert property (RD_REQ && !RD_DIRECT |-> MEM_RD_EN == !RD_PTR[15] && EXT_RD_EN == RD_PTR[15])
      else $error("read routing wrong");
   a_rd_word: assert property (RD_REQ && !RD_DIRECT && !RD_PTR[15] |-> MEM_RD_ADDR == {1'b0, RD_PTR[14:1]})
      else $error("read word address wrong");
   a_near_addr: assert property (RD_REQ && RD_DIRECT && !RD_MOV |-> MEM_RD_ADDR == {3'h0, RD_LIT[12:1]})
      else $error("near address wrong");
   a_err_now: assert property (RD_REQ && !RD_BYTE && !RD_DIRECT && RD_PTR[0] |-> ADDR_ERR)
      else $error("misaligned read not flagged");
   a_trap_follow: assert property (1'b1 |=> ADDR_TRAP == $past(ADDR_ERR))
      else $error("trap timing wrong");
   a_wr_lane: assert property (WR_REQ && WR_BYTE && !WR_DIRECT && !WR_PTR[15] |->
      MEM_WR_LANE == (WR_PTR[0] ? 2'h2 : 2'h1))
      else $error("byte lane wrong");
   a_wr_block: assert property (WR_REQ && !WR_BYTE && !WR_DIRECT && WR_PTR[0] |-> MEM_WR_LANE == 2'h0 && !EXT_WR_EN)
      else $error("misaligned write not blocked");
   a_wr_addr: assert property (WR_REQ && !WR_DIRECT && !WR_PTR[15] |-> MEM_WR_ADDR == {1'b0, WR_PTR[14:1]})
      else $error("write address wrong");
   a_otp_keep: assert property (NVM_ERASE_OK ==
      (NVM_ERASE && !(NVM_ADDR >= 24'h801700 && NVM_ADDR <= 24'h8017fe)))
      else $error("one-time area erasable");
   a_cfg_load: assert property ($fell(SRST) |-> CFG_BUSY ##[1:12] !CFG_BUSY)
      else $error("config load length wrong");
   // Main scenarios reached
   c_trap: cover property (ADDR_TRAP);
   c_byte_rd: cover property (RD_REQ && RD_BYTE);
   c_ext_rd: cover property (EXT_RD_EN);
endmodule
bind dsa_unit dsa_unit_chk dsa_unit_chk_inst (.*);

// >>> dv/dsa_mem_model.sv
// Byte-lane data memory and window model
`timescale 1ns/10ps
module dsa_mem_model (
   // Strobes and addresses
   input wire logic clk, rd_en, ext_en,
   input wire logic [14:0] rd_addr, wr_addr,
   input wire logic [1:0] lane,
   // Data
   input wire logic [15:0] wr_data,
   output logic [15:0] rd_data, ext_data
);
   logic [15:0] mem [16];
   // Lane writes, answers one cycle late, scrambled when idle
   always_ff @(posedge clk) begin
      if (lane[0]) mem[wr_addr[3:0]][7:0] <= wr_data[7:0];
      if (lane[1]) mem[wr_addr[3:0]][15:8] <= wr_data[15:8];
      rd_data <= rd_en ? mem[rd_addr[3:0]] : ~rd_data;
      ext_data <= ext_en ? 16'hc3a5 : ~ext_data;
   end
endmodule

// >>> dv/dsa_unit_tb.sv
// Self-checking testbench for the data-space access unit
`timescale 1ns/10ps
module dsa_unit_tb;
   logic CLK = 0, SRST = 1, RD_REQ = 0, RD_BYTE = 0, RD_DIRECT = 0, RD_MOV = 0, RD_POSTINC = 1;
   logic WR_REQ = 0, WR_BYTE = 0, WR_DIRECT = 0, WR_MOV = 0, WR_POSTINC = 1, SFR_RD_HIT = 1, NVM_ERASE = 0;
   logic [15:0] RD_PTR = 0, RD_LIT = 0, WR_PTR = 0, WR_LIT = 0, WR_DATA = 0, WREG_OLD = 0;
   logic [15:0] MEM_RD_DATA, EXT_RD_DATA, RD_PTR_NEXT, WR_PTR_NEXT, MEM_WR_DATA, RD_DATA, WREG_NEW, CFG_DATA, nxt;
   logic [14:0] MEM_RD_ADDR, MEM_WR_ADDR, ad;
   logic [1:0] EXT_OP = 0, MEM_WR_LANE, ln;
   logic MEM_RD_EN, EXT_RD_EN, EXT_WR_EN, ADDR_ERR, ADDR_TRAP, CFG_BUSY, ALT_TABLE_ON, NVM_ERASE_OK, err, en, trp;
   logic [3:0] CFG_INDEX;
   logic [12:0] SEGMENT_LIMIT_FIELD;
   logic [23:0] PRIVILEGED_CODE_SEGMENT, UNPRIVILEGED_CODE_SEGMENT, ALTERNATE_VECTOR_TABLE, NVM_ADDR = 0;
   int n_mismatch = 0, tests_run = 0;
   // ============================================================
   // Design, memory model, clock
   assign CFG_DATA = (CFG_INDEX == 4'h1) ? 16'h0004 : 16'h0000; // Limit 4, alternate table on
   dsa_unit dsa_unit_inst (.*);
   dsa_mem_model dsa_mem_model_inst (.clk(CLK), .rd_en(MEM_RD_EN), .ext_en(EXT_RD_EN), .rd_addr(MEM_RD_ADDR),
      .wr_addr(MEM_WR_ADDR), .lane(MEM_WR_LANE), .wr_data(MEM_WR_DATA), .rd_data(MEM_RD_DATA), .ext_data(EXT_RD_DATA));
   always #2.5 CLK = ~CLK;
   // ============================================================
   // Shared tasks
   task chk(input string s, input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task rd(input logic [15:0] a, input logic b);
      @(posedge CLK) #1 RD_PTR = a;
      RD_BYTE = b;
      RD_REQ = 1;
      #1 {err, en, nxt, ad} = {ADDR_ERR, MEM_RD_EN, RD_PTR_NEXT, MEM_RD_ADDR};
      @(posedge CLK) #1 RD_REQ = 0;
      #1;
   endtask
   task wr(input logic [15:0] a, input logic b, input logic [15:0] d);
      @(posedge CLK) #1 WR_PTR = a;
      WR_BYTE = b;
      WR_DATA = d;
      WR_REQ = 1;
      #1 {err, ln, nxt, en, ad} = {ADDR_ERR, MEM_WR_LANE, WR_PTR_NEXT, EXT_WR_EN, MEM_WR_ADDR};
      @(posedge CLK) #1 WR_REQ = 0;
      trp = ADDR_TRAP;
   endtask
   task report_and_stop;
      $display("mismatches %0d checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ============================================================
   // Scenarios
   task t_cfg;
      chk("busy", CFG_BUSY, 1);
      for (int i = 0; i < 40 && CFG_BUSY !== 1'b0; i++) @(posedge CLK);
      repeat (2) @(posedge CLK);
      #1 chk("limit", SEGMENT_LIMIT_FIELD, 4);
      chk("priv", PRIVILEGED_CODE_SEGMENT, 24'h000100);
      chk("alt", ALTERNATE_VECTOR_TABLE, 24'h001800);
      chk("alton", ALT_TABLE_ON, 1);
      chk("unpriv", UNPRIVILEGED_CODE_SEGMENT, 24'h002000);
   endtask
   task t_lanes;
      WREG_OLD = 16'habcd;
      wr(16'h1002, 0, 16'h3344);
      wr(16'h1003, 1, 16'h0012);
      chk("lane", ln, 2'h2);
      chk("wbstep", nxt, 16'h1004);
      rd(16'h1002, 0);
      chk("word", RD_DATA, 16'h1244);
      rd(16'h1003, 1);
      chk("byte", RD_DATA, 16'h0012);
      chk("bstep", nxt, 16'h1004);
      chk("merge", WREG_NEW, 16'hab12);
   endtask
   task t_misalign;
      wr(16'h1003, 0, 16'hffff);
      chk("werr", err, 1);
      chk("wwstep", nxt, 16'h1005);
      chk("wlane", ln, 2'h0);
      chk("trap", trp, 1);
      rd(16'h1002, 0);
      chk("kept", RD_DATA, 16'h1244);
      rd(16'h1003, 0);
      chk("rerr", err, 1);
      chk("rdone", en, 1);
      chk("wstep", nxt, 16'h1005);
   endtask
   task t_ext;
      wr(16'h8002, 0, 16'h5555);
      chk("extwr", en, 1);
      chk("extlane", ln, 2'h0);
      rd(16'h8000, 0);
      chk("memoff", en, 0);
      chk("ext", RD_DATA, 16'hc3a5);
      WREG_OLD = 16'h1280;
      EXT_OP = 2'h1;
      #1 chk("sext", WREG_NEW, 16'hff80);
      EXT_OP = 2'h2;
      #1 chk("zext", WREG_NEW, 16'h0080);
      EXT_OP = 2'h0;
   endtask
   task t_sfr_direct;
      SFR_RD_HIT = 0;
      rd(16'h0100, 0);
      chk("sfr", RD_DATA, 16'h0000);
      SFR_RD_HIT = 1;
      RD_DIRECT = 1;
      RD_LIT = 16'hf002;
      rd(16'h0000, 0);
      chk("near", ad, 15'h0801);
      RD_MOV = 1;
      RD_LIT = 16'h9000;
      rd(16'h0000, 0);
      chk("movfar", en, 0);
      {RD_DIRECT, RD_MOV} = 2'h0;
      WR_DIRECT = 1;
      WR_LIT = 16'hf004;
      wr(16'h0000, 0, 16'h0000);
      chk("wnear", ad, 15'h0802);
      WR_MOV = 1;
      WR_LIT = 16'h9000;
      wr(16'h0000, 0, 16'h0000);
      chk("wmovfar", en, 1);
      {WR_DIRECT, WR_MOV} = 2'h0;
   endtask
   task t_nvm;
      logic [23:0] tab [4] = '{24'h801700, 24'h8017fe, 24'h8016fe, 24'h801800};
      NVM_ERASE = 1;
      for (int i = 0; i < 4; i++) begin // Both ends of the one-time area, then one address just below and one just above it
         NVM_ADDR = tab[i];
         #1 chk("erase", NVM_ERASE_OK, i > 1);
      end
      NVM_ERASE = 0;
      #1 chk("noerase", NVM_ERASE_OK, 0);
   endtask
   // ============================================================
   // Main sequence and watchdog
   initial begin
      repeat (12) @(posedge CLK);
      #1 SRST = 0;
      t_cfg;
      t_lanes;
      t_misalign;
      t_ext;
      t_sfr_direct;
      t_nvm;
      report_and_stop;
   end
   initial begin
      #20000;
      n_mismatch++;
      report_and_stop;
   end
endmodule
